// *** hw/log_mode_params.svh ***
`ifndef LOG_MODE_PARAMS_SVH
`define LOG_MODE_PARAMS_SVH
`define OP_MODE_SELECT6 8'h15
`define OP_READ6 8'h08
`define OP_READ10 8'h28
`define OP_WRITE6 8'h0A
`define OP_WRITE10 8'h2A
`define OP_WRVERIFY10 8'h2E
`define OP_WRVERIFY16 8'h8E
`define RSV_PAGE_CODE 8'h30
`define RSV_PAGE_LEN 8'h30
`define RSV_PARAM_LEN 8'h2C
`define RSV_LAST_BYTE 6'h33
`define CNT_PAGE_CODE 8'h37
`define CNT_PAGE_LEN 8'h30
`define CNT_PARAM_LEN 8'h2C
`define CNT_LAST_BYTE 6'h33
`define HDR_LEN 8'h04
`define BLKDESC_LEN 8'h08
`define SP_BIT 0
`define SK_ILLEGAL_REQUEST 4'h5
`define ASC_PARAMS_CHANGED 8'h2A
`define HOURS_SECONDS 32'h0000_0E10
`endif

// *** hw/log_mode_pkg.sv ***
package log_mode_pkg;
    // lifetime counters, kept as one group so they can be saved and restored as a unit
    typedef struct packed {
        logic [31:0] power_on_hours;
        logic [7:0] max_temp;
        logic [7:0] exc_count;
        logic media_exception_flag;
        logic hardware_exception_flag;
        logic [63:0] read_cmds;
        logic [63:0] write_cmds;
        logic [15:0] flash_corr;
    } life_counters_t;
    // command status answer
    typedef struct packed {
        logic done;
        logic check_cond;
        logic [3:0] sense_key;
    } cmd_status_t;
    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_BLK, ST_PAGE} parse_state_t;
endpackage : log_mode_pkg

// *** hw/log_counters_mode_select.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "log_mode_params.svh"

// Overview of operation
// RQ1: reserved page: one zero parameter, 44 bytes
// RQ2: power-on hours big-endian, bytes eight to eleven
// RQ3: byte 28 holds lifetime maximum temperature
// RQ4: byte 31 counts informational exceptions other than warnings, saturating at FFh
// RQ5: exception warnings never add to count
// RQ6: byte 32 media bit7, hardware bit6 flags
// RQ7: eight-byte counter of read 6/10 commands
// RQ8: eight-byte counter of all write-type commands
// RQ9: two-byte flash ECC correction counter
// RQ10: opcode 15h is six-byte mode select
// RQ11: one mode page set for all initiators
// RQ12: page format bit ignored, always paged
// RQ13: save bit zero applies pages, not stored
// RQ14: save bit one stores pages to media
// RQ15: zero list length: no transfer, no error
// RQ16: header, optional block descriptor, then pages
// RQ17: wrong page length gives illegal request
// RQ18: initiator should read changeable values first; the bench model sends its list with no such query
// RQ19: parameters changed attention for other initiators
// RQ20: counters nonvolatile, never cleared by mode select
module log_counters_mode_select #(
    parameter int INIT_W = 3,
    parameter int PAGE_W = 8,
    parameter int SECS_PER_HOUR = 3600
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // command descriptor block
    input wire logic cdb_valid_i,
    input wire logic [7:0] cdb_op_i,
    input wire logic [7:0] cdb_b1_i,
    input wire logic [7:0] cdb_b4_i,
    input wire logic [INIT_W-1:0] cdb_init_i,
    // mode select data out bytes
    input wire logic dout_valid_i,
    input wire logic [7:0] dout_byte_i,
    // expected page length for the page code in flight
    output logic [5:0] page_code_o,
    input wire logic [7:0] page_len_exp_i,
    // events and measurements
    input wire logic second_tick_i,
    input wire logic [7:0] temp_i,
    input wire logic ie_event_i,
    input wire logic ie_warning_i,
    input wire logic ie_media_i,
    input wire logic ie_hardware_i,
    input wire logic ecc_corr_i,
    // nonvolatile restore of counters
    input wire logic nv_load_i,
    input wire log_mode_pkg::life_counters_t nv_data_i,
    output log_mode_pkg::life_counters_t life_o,
    // log page byte read
    input wire logic [7:0] log_page_i,
    input wire logic [5:0] log_addr_i,
    output logic [7:0] log_byte_o,
    // mode page byte to the shared set
    output logic mode_we_o,
    output logic [7:0] mode_byte_o,
    output logic save_req_o,
    output logic xfer_req_o,
    // status and attention
    output log_mode_pkg::cmd_status_t status_o,
    output logic [(1<<INIT_W)-1:0] ua_set_o,
    output logic [7:0] ua_asc_o
);
    log_mode_pkg::life_counters_t life_r;
    log_mode_pkg::parse_state_t st_r;
    logic [7:0] remain_r;
    logic [7:0] pos_r;
    logic [7:0] blk_len_r;
    logic [7:0] pg_len_r;
    logic sp_r;
    logic bad_r;
    logic [INIT_W-1:0] init_r;
    logic [$clog2(SECS_PER_HOUR+1)-1:0] sec_cnt_r;
    logic [7:0] log_byte_r;
    logic [5:0] page_code_r;
    logic mode_we_r;
    logic [7:0] mode_byte_r;
    logic save_r;
    logic xfer_r;
    log_mode_pkg::cmd_status_t status_r;
    logic [(1<<INIT_W)-1:0] ua_r;

    // command decode
    wire is_read = cdb_valid_i && (cdb_op_i == `OP_READ6 || cdb_op_i == `OP_READ10);
    wire is_write = cdb_valid_i && (cdb_op_i == `OP_WRITE6 || cdb_op_i == `OP_WRITE10 ||
        cdb_op_i == `OP_WRVERIFY10 || cdb_op_i == `OP_WRVERIFY16);
    wire is_msel = cdb_valid_i && cdb_op_i == `OP_MODE_SELECT6 && st_r == log_mode_pkg::ST_IDLE; // RQ10
    wire hour_done = second_tick_i && sec_cnt_r == ($bits(sec_cnt_r))'(SECS_PER_HOUR - 1);
    wire last_byte = dout_valid_i && remain_r == 8'h01;
    wire [7:0] pos_nxt = pos_r + 8'h01;

    // lifetime counters; restore from nonvolatile copy, never touched by mode select
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sec_cnt_r <= '0;
        else if (second_tick_i)
            sec_cnt_r <= hour_done ? '0 : sec_cnt_r + 1'b1; // RQ2
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            life_r <= '0;
        else if (nv_load_i)
            life_r <= nv_data_i; // RQ20
        else
        begin
            if (hour_done)
                life_r.power_on_hours <= life_r.power_on_hours + 32'h0000_0001; // RQ2
            if (temp_i > life_r.max_temp)
                life_r.max_temp <= temp_i; // RQ3
            // warnings alone do not count; saturate rather than wrap
            if (ie_event_i && !ie_warning_i && life_r.exc_count != 8'hFF)
                life_r.exc_count <= life_r.exc_count + 8'h01; // RQ4 RQ5
            if (ie_event_i && ie_media_i)
                life_r.media_exception_flag <= 1'b1; // RQ6
            if (ie_event_i && ie_hardware_i)
                life_r.hardware_exception_flag <= 1'b1; // RQ6
            if (is_read)
                life_r.read_cmds <= life_r.read_cmds + 64'h1; // RQ7
            if (is_write)
                life_r.write_cmds <= life_r.write_cmds + 64'h1; // RQ8
            if (ecc_corr_i)
                life_r.flash_corr <= life_r.flash_corr + 16'h0001; // RQ9
        end
    end

    // log page byte mux
    logic [7:0] cnt_byte;
    always_comb
    begin
        case (log_addr_i)
            6'h00: cnt_byte = `CNT_PAGE_CODE;
            6'h03: cnt_byte = `CNT_PAGE_LEN;
            6'h07: cnt_byte = `CNT_PARAM_LEN;
            6'h08: cnt_byte = life_r.power_on_hours[31:24]; // RQ2
            6'h09: cnt_byte = life_r.power_on_hours[23:16];
            6'h0A: cnt_byte = life_r.power_on_hours[15:8];
            6'h0B: cnt_byte = life_r.power_on_hours[7:0];
            6'h1C: cnt_byte = life_r.max_temp; // RQ3
            6'h1F: cnt_byte = life_r.exc_count; // RQ4
            6'h20: cnt_byte = {life_r.media_exception_flag, life_r.hardware_exception_flag,
                6'h00}; // RQ6
            6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28:
                cnt_byte = life_r.read_cmds[8*(6'h28 - log_addr_i) +: 8]; // RQ7
            6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h30:
                cnt_byte = life_r.write_cmds[8*(6'h30 - log_addr_i) +: 8]; // RQ8
            6'h32: cnt_byte = life_r.flash_corr[15:8]; // RQ9
            6'h33: cnt_byte = life_r.flash_corr[7:0];
            default: cnt_byte = 8'h00;
        endcase
    end

    // reserved page: header then all-zero parameter bytes
    logic [7:0] rsv_byte;
    always_comb
    begin
        case (log_addr_i)
            6'h00: rsv_byte = `RSV_PAGE_CODE;
            6'h03: rsv_byte = `RSV_PAGE_LEN;
            6'h07: rsv_byte = `RSV_PARAM_LEN; // RQ1
            default: rsv_byte = 8'h00; // RQ1
        endcase
    end

    wire [7:0] log_sel = (log_page_i == `CNT_PAGE_CODE && log_addr_i <= `CNT_LAST_BYTE) ?
        cnt_byte : (log_page_i == `RSV_PAGE_CODE && log_addr_i <= `RSV_LAST_BYTE) ?
        rsv_byte : 8'h00;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            log_byte_r <= 8'h00;
        else
            log_byte_r <= log_sel;
    end

    // mode select parameter list parser; pages go to a single shared set
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= log_mode_pkg::ST_IDLE;
            remain_r <= 8'h00;
            pos_r <= 8'h00;
            blk_len_r <= 8'h00;
            pg_len_r <= 8'h00;
            sp_r <= 1'b0;
            bad_r <= 1'b0;
            init_r <= '0;
            page_code_r <= 6'h00;
            mode_we_r <= 1'b0;
            mode_byte_r <= 8'h00;
            save_r <= 1'b0;
            xfer_r <= 1'b0;
            status_r <= '0;
            ua_r <= '0;
        end
        else
        begin
            mode_we_r <= 1'b0;
            status_r <= '0;
            ua_r <= '0;
            save_r <= 1'b0;
            xfer_r <= 1'b0;
            case (st_r)
                log_mode_pkg::ST_IDLE:
                    if (is_msel)
                    begin
                        sp_r <= cdb_b1_i[`SP_BIT]; // RQ12
                        init_r <= cdb_init_i;
                        bad_r <= 1'b0;
                        pos_r <= 8'h00;
                        remain_r <= cdb_b4_i;
                        if (cdb_b4_i == 8'h00)
                            status_r.done <= 1'b1; // RQ15
                        else
                        begin
                            xfer_r <= 1'b1;
                            st_r <= log_mode_pkg::ST_HDR;
                        end
                    end
                log_mode_pkg::ST_HDR:
                    if (dout_valid_i)
                    begin
                        remain_r <= remain_r - 8'h01;
                        pos_r <= pos_nxt;
                        if (pos_r == 8'h03)
                        begin
                            blk_len_r <= dout_byte_i;
                            // at most one descriptor, eight bytes
                            if (dout_byte_i != 8'h00 && dout_byte_i != `BLKDESC_LEN)
                                bad_r <= 1'b1; // RQ16
                            pos_r <= 8'h00;
                            st_r <= (dout_byte_i != 8'h00) ? log_mode_pkg::ST_BLK :
                                log_mode_pkg::ST_PAGE; // RQ16
                        end
                    end
                log_mode_pkg::ST_BLK:
                    if (dout_valid_i)
                    begin
                        remain_r <= remain_r - 8'h01;
                        pos_r <= pos_nxt;
                        if (pos_nxt == blk_len_r)
                        begin
                            pos_r <= 8'h00;
                            st_r <= log_mode_pkg::ST_PAGE;
                        end
                    end
                log_mode_pkg::ST_PAGE:
                    if (dout_valid_i)
                    begin
                        remain_r <= remain_r - 8'h01;
                        pos_r <= pos_nxt;
                        mode_byte_r <= dout_byte_i;
                        mode_we_r <= !bad_r; // RQ11 RQ13
                        if (pos_r == 8'h00)
                            page_code_r <= dout_byte_i[5:0];
                        if (pos_r == 8'h01)
                        begin
                            pg_len_r <= dout_byte_i;
                            if (dout_byte_i != page_len_exp_i)
                                bad_r <= 1'b1; // RQ17
                        end
                        if (pos_r > 8'h01 && pos_nxt == pg_len_r + 8'h02)
                            pos_r <= 8'h00;
                    end
                default: st_r <= log_mode_pkg::ST_IDLE;
            endcase
            // end of list closes the command
            if (st_r != log_mode_pkg::ST_IDLE && last_byte)
            begin
                st_r <= log_mode_pkg::ST_IDLE;
                status_r.done <= 1'b1;
                if (bad_r || (st_r == log_mode_pkg::ST_PAGE && pos_r == 8'h01 &&
                    dout_byte_i != page_len_exp_i))
                begin
                    status_r.check_cond <= 1'b1; // RQ17
                    status_r.sense_key <= `SK_ILLEGAL_REQUEST;
                end
                else
                begin
                    save_r <= sp_r; // RQ14
                    ua_r <= ~({{((1<<INIT_W)-1){1'b0}}, 1'b1} << init_r); // RQ19
                end
            end
        end
    end

    // outputs
    assign page_code_o = page_code_r;
    assign life_o = life_r;
    assign log_byte_o = log_byte_r;
    assign mode_we_o = mode_we_r;
    assign mode_byte_o = mode_byte_r;
    assign save_req_o = save_r;
    assign xfer_req_o = xfer_r;
    assign status_o = status_r;
    assign ua_set_o = ua_r;
    assign ua_asc_o = `ASC_PARAMS_CHANGED; // RQ19

    a_warn_no_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (ie_warning_i && !nv_load_i) |=> $stable(life_r.exc_count)) // RQ5
        else $error("warning changed exception count");
    a_read_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_read && !nv_load_i) |=> life_r.read_cmds == $past(life_r.read_cmds) + 64'h1) // RQ7
        else $error("read counter missed");
    a_write_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_write && !nv_load_i) |=> life_r.write_cmds == $past(life_r.write_cmds) + 64'h1) // RQ8
        else $error("write counter missed");
    a_ecc_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (ecc_corr_i && !nv_load_i) |=> life_r.flash_corr != $past(life_r.flash_corr)) // RQ9
        else $error("ecc counter missed");
    a_max_temp: assert property (@(posedge clk_i) disable iff (rst_i)
        !nv_load_i |=> life_r.max_temp >= $past(temp_i)) // RQ3
        else $error("max temperature below sample");
    a_zero_len: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_msel && cdb_b4_i == 8'h00) |=> status_r.done && !xfer_r && !status_r.check_cond) // RQ15
        else $error("zero length mishandled");
    a_media_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (ie_event_i && ie_media_i && !nv_load_i) |=> life_r.media_exception_flag) // RQ6
        else $error("media flag not set");
    a_ua_issuer: assert property (@(posedge clk_i) disable iff (rst_i)
        ua_r != '0 |-> !ua_r[init_r] && !status_r.check_cond) // RQ19
        else $error("attention sent to issuer");
endmodule : log_counters_mode_select
`default_nettype wire

// *** bench/scsi_initiator_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// initiator side: issues commands and streams a mode parameter list
module scsi_initiator_model #(
    parameter int INIT_W = 3,
    parameter logic [7:0] PAGE_LEN = 8'h02
) (
    // clock
    input wire logic clk_i,
    // command and data out
    output logic cdb_valid_o,
    output logic [7:0] cdb_op_o,
    output logic [7:0] cdb_b1_o,
    output logic [7:0] cdb_b4_o,
    output logic [INIT_W-1:0] cdb_init_o,
    output logic dout_valid_o,
    output logic [7:0] dout_byte_o,
    // page length lookup and transfer start
    input wire logic [5:0] page_code_i,
    output logic [7:0] page_len_exp_o,
    input wire logic xfer_req_i
);
    // only page 01h is known, its length fixed by the PAGE_LEN parameter
    assign page_len_exp_o = (page_code_i == 6'h01) ? PAGE_LEN : 8'hFF;
    initial
    begin
        {cdb_valid_o, cdb_op_o, cdb_b1_o, cdb_b4_o, cdb_init_o} = '0;
        {dout_valid_o, dout_byte_o} = '0;
    end
    // header, a block descriptor of dbl bytes, then one page of two data bytes
    function automatic logic [7:0] list_byte(input int k, input logic [7:0] plen,
        input logic [7:0] dbl);
        int p;
        p = 4 + dbl;
        if (k == 3) return dbl;
        if (k == p) return 8'h01;
        if (k == p + 1) return plen;
        if (k == p + 2) return 8'hA5;
        if (k == p + 3) return 8'h5A;
        return 8'h00;
    endfunction : list_byte
    // one command, then the list once the device asks for it
    task automatic send(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] len,
        input logic [INIT_W-1:0] init, input logic [7:0] plen, input logic [7:0] dbl);
        int w;
        {cdb_op_o, cdb_b1_o, cdb_b4_o, cdb_init_o, cdb_valid_o} = {op, b1, len, init, 1'b1};
        @(posedge clk_i);
        #2;
        {cdb_op_o, cdb_b1_o, cdb_b4_o, cdb_init_o, cdb_valid_o} = {~op, ~b1, ~len, ~init, 1'b0};
        if (op == 8'h15 && len != 8'h00)
        begin
            for (w = 0; w < 20 && xfer_req_i !== 1'b1; w++)
            begin
                @(posedge clk_i);
                #2;
            end
            for (w = 0; w < len; w++)
            begin
                dout_byte_o = list_byte(w, plen, dbl);
                dout_valid_o = 1'b1;
                @(posedge clk_i);
                #2;
            end
            dout_valid_o = 1'b0;
            dout_byte_o = ~dout_byte_o; // released line shows no stale byte
        end
        // one idle edge keeps back-to-back commands from merging
        @(posedge clk_i);
        #2;
    endtask : send
endmodule : scsi_initiator_model
`default_nettype wire

// *** bench/test_log_counters_mode_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_log_counters_mode_select;
    logic clk_i = 0, rst_i = 1, second_tick_i = 0, ie_event_i = 0, ie_warning_i = 0;
    logic ie_media_i = 0, ie_hardware_i = 0, ecc_corr_i = 0, nv_load_i = 0;
    logic [7:0] temp_i = 8'h00, log_page_i = 8'h30, log_byte_o, cdb_op_i, cdb_b1_i, cdb_b4_i;
    logic [7:0] dout_byte_i, page_len_exp_i, mode_byte_o, ua_asc_o, ua_set_o, ua_r, last_b;
    logic [7:0] ops [6] = '{8'h08, 8'h28, 8'h0A, 8'h2A, 8'h2E, 8'h8E};
    logic [5:0] log_addr_i = 6'h00, page_code_o;
    logic [2:0] cdb_init_i;
    logic cdb_valid_i, dout_valid_i, mode_we_o, save_req_o, xfer_req_o;
    log_mode_pkg::life_counters_t nv_data_i = '0, life_o;
    log_mode_pkg::cmd_status_t status_o, st_r;
    int failures = 0, tests_run = 0, n_done = 0, n_save = 0, n_we = 0, n_xfer = 0;
    int d0, s0, w0, x0;
    // a short hour keeps the run small
    log_counters_mode_select #(.SECS_PER_HOUR(3)) DUT (.clk_i, .rst_i, .cdb_valid_i,
        .cdb_op_i, .cdb_b1_i, .cdb_b4_i, .cdb_init_i, .dout_valid_i, .dout_byte_i,
        .page_code_o, .page_len_exp_i, .second_tick_i, .temp_i, .ie_event_i, .ie_warning_i,
        .ie_media_i, .ie_hardware_i, .ecc_corr_i, .nv_load_i, .nv_data_i, .life_o,
        .log_page_i, .log_addr_i, .log_byte_o, .mode_we_o, .mode_byte_o, .save_req_o,
        .xfer_req_o, .status_o, .ua_set_o, .ua_asc_o);
    scsi_initiator_model host (.clk_i, .cdb_valid_o(cdb_valid_i), .cdb_op_o(cdb_op_i),
        .cdb_b1_o(cdb_b1_i), .cdb_b4_o(cdb_b4_i), .cdb_init_o(cdb_init_i),
        .dout_valid_o(dout_valid_i), .dout_byte_o(dout_byte_i), .page_code_i(page_code_o),
        .page_len_exp_o(page_len_exp_i), .xfer_req_i(xfer_req_o));
    always #12.5 clk_i = ~clk_i;
    // one-cycle pulses are caught mid-cycle, where they have settled
    always @(negedge clk_i)
    begin
        if (status_o.done === 1'b1)
        begin
            n_done++;
            st_r = status_o;
            ua_r = ua_set_o;
        end
        if (save_req_o === 1'b1) n_save++;
        if (mode_we_o === 1'b1)
        begin
            n_we++;
            last_b = mode_byte_o;
        end
        if (xfer_req_o === 1'b1) n_xfer++;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    // log byte appears one cycle after the address
    task automatic rd(input logic [7:0] pg, input logic [5:0] a, input logic [7:0] exp);
        log_page_i = pg;
        log_addr_i = a;
        repeat (2) @(posedge clk_i);
        #2;
        check(log_byte_o, exp);
    endtask : rd
    // kind 0 second tick, 1 exception event, 2 flash correction
    task automatic ev(input int k, input int n);
        repeat (n)
        begin
            {second_tick_i, ie_event_i, ecc_corr_i} = 3'b100 >> k;
            @(posedge clk_i);
            #2;
            {second_tick_i, ie_event_i, ecc_corr_i} = 3'b000;
            @(posedge clk_i);
            #2;
        end
    endtask : ev
    task automatic ms(input logic [7:0] b1, input logic [7:0] len, input logic [2:0] init,
        input logic [7:0] plen, input logic [7:0] dbl);
        {d0, s0, w0, x0} = {n_done, n_save, n_we, n_xfer};
        host.send(8'h15, b1, len, init, plen, dbl);
        repeat (3) @(posedge clk_i);
        #2;
        check(n_done - d0, 1);
    endtask : ms
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial
    begin
        #(25 * 4000);
        failures++;
        conclude();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        #2 rst_i = 0;
        check(ua_asc_o, 8'h2A);
        rd(8'h30, 6'd3, 8'h30);
        rd(8'h30, 6'd7, 8'h2C);
        for (int a = 8; a < 52; a += 11) rd(8'h30, a[5:0], 8'h00);
        rd(8'h30, 6'd51, 8'h00);
        nv_data_i.flash_corr = 16'h0100;
        nv_load_i = 1;
        @(posedge clk_i);
        #2 nv_load_i = 0;
        temp_i = 8'h41;
        ev(0, 7); // seven seconds make two whole hours
        temp_i = 8'h20;
        rd(8'h37, 6'd11, 8'h02);
        rd(8'h37, 6'd8, 8'h00);
        rd(8'h37, 6'd28, 8'h41);
        ie_warning_i = 1;
        ev(1, 1);
        ie_warning_i = 0;
        rd(8'h37, 6'd31, 8'h00);
        ie_media_i = 1;
        ev(1, 1);
        ie_media_i = 0;
        rd(8'h37, 6'd32, 8'h80);
        ie_hardware_i = 1;
        ev(1, 2);
        ie_hardware_i = 0;
        rd(8'h37, 6'd31, 8'h03);
        rd(8'h37, 6'd32, 8'hC0);
        ev(2, 2);
        rd(8'h37, 6'd50, 8'h01);
        rd(8'h37, 6'd51, 8'h02);
        foreach (ops[i])
            host.send(ops[i], 8'h00, 8'h00, 3'h0, 8'h02, 8'h08);
        rd(8'h37, 6'd40, 8'h02);
        rd(8'h37, 6'd48, 8'h04);
        ms(8'h00, 8'h00, 3'h1, 8'h02, 8'h08);
        check({st_r.check_cond, n_xfer - x0}, 0);
        ms(8'h01, 8'h10, 3'h2, 8'h02, 8'h08);
        check(st_r.check_cond, 1'b0);
        check(n_save - s0, 1);
        check(n_we - w0, 4);
        check(n_xfer - x0, 1);
        check(last_b, 8'h5A);
        check(page_code_o, 6'h01);
        check(ua_r, 8'hFB);
        ms(8'h10, 8'h10, 3'h5, 8'h02, 8'h08);
        check({st_r.check_cond, n_save - s0}, 0);
        check(ua_r, 8'hDF);
        ms(8'h10, 8'h08, 3'h0, 8'h02, 8'h00);
        check({st_r.check_cond, n_we - w0}, 4);
        ms(8'h10, 8'h0C, 3'h0, 8'h02, 8'h04);
        check(st_r.check_cond, 1'b1);
        ms(8'h11, 8'h10, 3'h5, 8'h03, 8'h08);
        check({st_r.check_cond, st_r.sense_key}, 5'h15);
        check(n_save - s0, 0);
        check(ua_r, 8'h00);
        rd(8'h37, 6'd40, 8'h02);
        check(life_o.write_cmds, 64'h4);
        conclude();
    end
endmodule : test_log_counters_mode_select
`default_nettype wire
